// *** hdl/mabe_regs.vh ***
// Constants for the ALU and branch execution datapath
`ifndef MABE_REGS_VH
`define MABE_REGS_VH
// Operation codes from the sequencer
`define MABE_OP_NONE 4'h0
`define MABE_OP_ADD 4'h1
`define MABE_OP_SUB 4'h2
`define MABE_OP_CMP 4'h3
`define MABE_OP_AND 4'h4
`define MABE_OP_CLR 4'h5
`define MABE_OP_INC 4'h6
`define MABE_OP_DEC 4'h7
`define MABE_OP_COM 4'h8
`define MABE_OP_RLC 4'h9
`define MABE_OP_SLA 4'hA
`define MABE_OP_JR 4'hB
`define MABE_OP_JRB 4'hC
`define MABE_OP_JP 4'hD
// Short branch test kinds, opcode bits 7:5
`define MABE_JR_NZ 3'h0
`define MABE_JR_Z 3'h2
`define MABE_JR_NC 3'h4
`define MABE_JR_C 3'h6
// Operand sources
`define MABE_SRC_MEM 2'h0
`define MABE_SRC_IMM 2'h1
`define MABE_SRC_ACC 2'h2
// Register file locations
`define MABE_ADDR_X 8'h80
`define MABE_ADDR_Y 8'h81
`define MABE_ADDR_V 8'h82
`define MABE_ADDR_W 8'h83
// Cycle counts
`define MABE_CYC_ALU 3'h4
`define MABE_CYC_JR 3'h2
`define MABE_CYC_JRB 3'h5
`define MABE_CYC_JP 3'h4
// Reset values
`define MABE_RST_ACC 8'h00
`define MABE_RST_PC 12'h000
`endif

// *** hdl/mabe_alu.v ***
// Combinational arithmetic and logic unit with zero and carry results
`timescale 1ns/1ps
`default_nettype none
`include "mabe_regs.vh"
module mabe_alu (
  input wire [3:0] op,
  input wire [7:0] acc,
  input wire [7:0] opnd,
  input wire carry_in,
  output reg [7:0] result,
  output reg zero_out,
  output reg carry_out,
  output reg upd_carry,
  output reg wr_acc
);
  reg [8:0] sum;
  always @* begin
    sum = 9'h000;
    result = acc;
    carry_out = carry_in;
    upd_carry = 1'b0;
    wr_acc = 1'b1;
    case (op)
      `MABE_OP_ADD: begin
        sum = {1'b0, acc} + {1'b0, opnd};
        result = sum[7:0];
        carry_out = sum[8];
        upd_carry = 1'b1; // RULE_14
      end
      `MABE_OP_SUB, `MABE_OP_CMP: begin
        sum = {1'b0, acc} - {1'b0, opnd};
        result = sum[7:0];
        carry_out = sum[8];
        upd_carry = 1'b1; // RULE_14
        wr_acc = (op == `MABE_OP_SUB);
      end
      `MABE_OP_AND: begin
        result = acc & opnd;
      end
      `MABE_OP_CLR: begin
        result = 8'h00;
        wr_acc = 1'b0;
      end
      `MABE_OP_INC: begin
        result = opnd + 8'h01;
        wr_acc = 1'b0;
      end
      `MABE_OP_DEC: begin
        result = opnd - 8'h01;
        wr_acc = 1'b0;
      end
      `MABE_OP_COM: begin
        result = ~acc; // RULE_03
        carry_out = acc[7];
        upd_carry = 1'b1; // RULE_14
      end
      `MABE_OP_RLC: begin
        result = {acc[6:0], carry_in}; // RULE_03
        carry_out = acc[7];
        upd_carry = 1'b1; // RULE_14
      end
      `MABE_OP_SLA: begin
        result = {acc[6:0], 1'b0}; // RULE_03
        carry_out = acc[7];
        upd_carry = 1'b1; // RULE_14
      end
      default: begin
        wr_acc = 1'b0;
      end
    endcase
    zero_out = (result == 8'h00);
  end
endmodule // mabe_alu
`default_nettype wire

// *** hdl/mabe_exec.v ***
// ALU and conditional branch execution datapath of the core
// How it works
// [RULE_01] Add, subtract, compare and and take the accumulator plus a data byte or an immediate byte.
// [RULE_02] Clear, decrement and increment may target any of the 256 data-space bytes.
// [RULE_03] Complement, rotate through carry and shift left act only on the accumulator.
// [RULE_04] A conditional branch loads its target only when the condition holds, else falls through.
// [RULE_05] Short branches reach -15 to +16 locations around the branch via a 5-bit displacement.
// [RULE_06] Bit test branches use an 8-bit displacement reaching -126 to +129 around the instruction.
// [RULE_07] A 3-bit selector picks one of the eight bits of the tested byte.
// [RULE_08] Any bit of any data-space byte can be tested.
// [RULE_09] Jump and call carry a 12-bit target covering the whole program space.
// [RULE_10] Locations 80H and 81H act as indirect pointers; 80H to 83H have short-direct codes. Operand reads get the pointer itself; writes go through it.
// [RULE_11] Immediate operands come from the program byte following the opcode.
// [RULE_12] Short branch opcodes hold the test in bits 7:5, direction in bit 4 and span in bits 3:0.
// [RULE_13] Pointer and work registers sit at 80H to 83H with pointers at 80H and 81H.
// [RULE_14] Add, sub, compare, complement, rotate, shift set Z and C; and, inc, dec set Z; bit tests load C.
// [RULE_15] ALU ops take four cycles, short branches two, bit test branches five, taken or not.
`timescale 1ns/1ps
`default_nettype none
`include "mabe_regs.vh"
module mabe_exec (
  input wire clock,
  input wire rstn,
  input wire start,
  input wire [3:0] op,
  input wire [1:0] src,
  input wire [7:0] opcode,
  input wire [7:0] prog_byte1,
  input wire [7:0] prog_byte2,
  input wire [1:0] addr_mode,
  input wire [11:0] instr_pc,
  input wire [7:0] mem_rdata,
  output reg [7:0] mem_addr,
  output reg mem_rd,
  output reg mem_wr,
  output reg [7:0] mem_wdata,
  output reg [7:0] acc_out,
  output reg zero_flag,
  output reg carry_flag,
  output reg [11:0] pc_out,
  output reg pc_load,
  output reg busy,
  output reg done
);
  // ====================================================
  // Addressing modes for the data operand
  localparam AM_DIRECT = 2'h0;
  localparam AM_SHORT = 2'h1;
  localparam AM_IND_X = 2'h2;
  localparam AM_IND_Y = 2'h3;

  // ====================================================
  // States
  localparam ST_IDLE = 3'h0;
  localparam ST_PTR = 3'h1;
  localparam ST_READ = 3'h2;
  localparam ST_EXEC = 3'h3;
  localparam ST_WAIT = 3'h4;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [2:0] cnt_r;
  reg [3:0] op_r;
  reg [1:0] src_r;
  reg [7:0] opc_r;
  reg [7:0] b1_r;
  reg [7:0] b2_r;
  reg [1:0] am_r;
  reg [11:0] ipc_r;
  reg [7:0] opnd_r;
  reg [7:0] addr_r;
  reg [7:0] acc_r;
  reg z_r;
  reg c_r;

  wire [7:0] alu_res;
  wire alu_z;
  wire alu_c;
  wire alu_upd_c;
  wire alu_wr_acc;
  wire [7:0] alu_b;

  // ====================================================
  // Operand selection
  assign alu_b = (src_r == `MABE_SRC_IMM) ? b1_r : opnd_r; // RULE_01 RULE_11

  mabe_alu u_alu (
    .op(op_r),
    .acc(acc_r),
    .opnd(alu_b),
    .carry_in(c_r),
    .result(alu_res),
    .zero_out(alu_z),
    .carry_out(alu_c),
    .upd_carry(alu_upd_c),
    .wr_acc(alu_wr_acc)
  );

  // ====================================================
  // Branch decisions and targets
  reg jr_cond;
  reg [11:0] jr_target;
  reg [11:0] jrb_target;
  reg tested_bit;
  always @* begin
    case (opc_r[7:5]) // RULE_12
      `MABE_JR_NZ: jr_cond = ~z_r;
      `MABE_JR_Z: jr_cond = z_r;
      `MABE_JR_NC: jr_cond = ~c_r;
      `MABE_JR_C: jr_cond = c_r;
      default: jr_cond = 1'b0;
    endcase
    // Span 0..F forward gives +1..+16, backward -0..-15
    if (opc_r[4]) begin
      jr_target = ipc_r - {8'h00, opc_r[3:0]}; // RULE_05
    end else begin
      jr_target = ipc_r + {8'h00, opc_r[3:0]} + 12'h001; // RULE_05
    end
    // Displacement counted from two past the branch
    jrb_target = ipc_r + 12'h002 + {{4{b2_r[7]}}, b2_r}; // RULE_06
    tested_bit = opnd_r[opc_r[7:5]]; // RULE_07 RULE_08
  end

  // Operand address from opcode, following byte or pointer
  reg [7:0] dir_addr;
  always @* begin
    case (am_r)
      AM_SHORT: dir_addr = `MABE_ADDR_X | {6'h00, opc_r[3:2]}; // RULE_10 RULE_13
      AM_IND_X: dir_addr = `MABE_ADDR_X; // RULE_10 RULE_13
      AM_IND_Y: dir_addr = `MABE_ADDR_Y; // RULE_10 RULE_13
      default: dir_addr = b1_r; // RULE_02
    endcase
  end

  wire uses_mem = (op_r == `MABE_OP_JRB) ||
    ((op_r != `MABE_OP_COM) && (op_r != `MABE_OP_RLC) && (op_r != `MABE_OP_SLA) &&
     (src_r == `MABE_SRC_MEM));
  wire wr_mem = (op_r == `MABE_OP_CLR) || (op_r == `MABE_OP_INC) || (op_r == `MABE_OP_DEC);
  wire mem_target = wr_mem && (src_r == `MABE_SRC_MEM);

  // ====================================================
  // Sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = ST_PTR;
        end
      end
      ST_PTR: begin
        if (op_r == `MABE_OP_JR || op_r == `MABE_OP_JP || !uses_mem) begin
          state_nxt = ST_EXEC;
        end else begin
          state_nxt = ST_READ;
        end
      end
      ST_READ: state_nxt = ST_EXEC;
      ST_EXEC: begin
        if (cnt_r == 3'h0) begin
          state_nxt = ST_IDLE;
        end else begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cnt_r == 3'h0) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
      op_r <= `MABE_OP_NONE;
      src_r <= `MABE_SRC_MEM;
      opc_r <= 8'h00;
      b1_r <= 8'h00;
      b2_r <= 8'h00;
      am_r <= AM_DIRECT;
      ipc_r <= `MABE_RST_PC;
      opnd_r <= 8'h00;
      addr_r <= 8'h00;
      acc_r <= `MABE_RST_ACC;
      z_r <= 1'b0;
      c_r <= 1'b0;
      mem_addr <= 8'h00;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_wdata <= 8'h00;
      acc_out <= `MABE_RST_ACC;
      zero_flag <= 1'b0;
      carry_flag <= 1'b0;
      pc_out <= `MABE_RST_PC;
      pc_load <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      pc_load <= 1'b0;
      done <= 1'b0;
      if (cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
      end
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            op_r <= op;
            src_r <= src;
            opc_r <= opcode;
            b1_r <= prog_byte1;
            b2_r <= prog_byte2;
            am_r <= addr_mode;
            ipc_r <= instr_pc;
            busy <= 1'b1;
            case (op) // RULE_15
              `MABE_OP_JR: cnt_r <= `MABE_CYC_JR - 3'h1;
              `MABE_OP_JRB: cnt_r <= `MABE_CYC_JRB - 3'h1;
              `MABE_OP_JP: cnt_r <= `MABE_CYC_JP - 3'h1;
              default: cnt_r <= `MABE_CYC_ALU - 3'h1;
            endcase
          end
        end
        ST_PTR: begin
          // Indirect modes read the pointer first
          if (uses_mem) begin
            mem_addr <= dir_addr;
            mem_rd <= 1'b1;
            addr_r <= dir_addr;
          end
        end
        ST_READ: begin
          if (am_r == AM_IND_X || am_r == AM_IND_Y) begin
            addr_r <= mem_rdata;
            mem_addr <= mem_rdata;
            opnd_r <= mem_rdata;
          end else begin
            opnd_r <= mem_rdata;
          end
        end
        ST_EXEC: begin
          case (op_r)
            `MABE_OP_JR: begin
              if (jr_cond) begin
                pc_out <= jr_target; // RULE_04
                pc_load <= 1'b1; // RULE_04
              end
            end
            `MABE_OP_JRB: begin
              c_r <= tested_bit; // RULE_14
              carry_flag <= tested_bit;
              if (tested_bit == opc_r[4]) begin
                pc_out <= jrb_target; // RULE_04
                pc_load <= 1'b1; // RULE_04
              end
            end
            `MABE_OP_JP: begin
              pc_out <= {opc_r[3:0], b1_r}; // RULE_09
              pc_load <= 1'b1;
            end
            `MABE_OP_NONE: begin
            end
            default: begin
              if (mem_target) begin
                mem_addr <= addr_r; // RULE_02
                mem_wdata <= alu_res;
                mem_wr <= 1'b1;
              end else if (wr_mem || alu_wr_acc) begin
                acc_r <= (op_r == `MABE_OP_CLR) ? 8'h00 :
                  (op_r == `MABE_OP_INC) ? acc_r + 8'h01 :
                  (op_r == `MABE_OP_DEC) ? acc_r - 8'h01 : alu_res;
                acc_out <= (op_r == `MABE_OP_CLR) ? 8'h00 :
                  (op_r == `MABE_OP_INC) ? acc_r + 8'h01 :
                  (op_r == `MABE_OP_DEC) ? acc_r - 8'h01 : alu_res;
              end
              // Inc and dec of A derive zero from A itself
              if (!mem_target && (op_r == `MABE_OP_INC)) begin
                z_r <= (acc_r + 8'h01) == 8'h00; // RULE_14
                zero_flag <= (acc_r + 8'h01) == 8'h00;
              end else if (!mem_target && (op_r == `MABE_OP_DEC)) begin
                z_r <= (acc_r - 8'h01) == 8'h00; // RULE_14
                zero_flag <= (acc_r - 8'h01) == 8'h00;
              end else if (!(mem_target && op_r == `MABE_OP_CLR)) begin
                z_r <= alu_z; // RULE_14
                zero_flag <= alu_z;
              end
              if (alu_upd_c) begin
                c_r <= alu_c; // RULE_14
                carry_flag <= alu_c;
              end
              if (!mem_target && op_r == `MABE_OP_CLR) begin
                c_r <= 1'b0;
                carry_flag <= 1'b0;
              end
            end
          endcase
          // Short branches finish here, others wait for the count
          if (cnt_r == 3'h0) begin // RULE_15
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
        ST_WAIT: begin
          if (cnt_r == 3'h0) begin // RULE_15
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end
endmodule // mabe_exec
`default_nettype wire

// *** sim/mabe_mem_model.sv ***
// Data space memory model facing the execution datapath
`timescale 1ns/1ps
`default_nettype none
module mabe_mem_model (
  input wire logic clock,
  input wire logic [7:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:255];
  // Read data stands while the strobe is high, inverted otherwise
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
  always @(posedge clock) begin
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end
endmodule // mabe_mem_model
`default_nettype wire

// *** sim/mabe_exec_sva.sv ***
// Port assertions for the execution datapath
`timescale 1ns/1ps
`default_nettype none
`include "mabe_regs.vh"
module mabe_exec_sva (
  input wire logic clock,
  input wire logic rstn,
  input wire logic start,
  input wire logic [3:0] op,
  input wire logic [1:0] src,
  input wire logic [7:0] opcode,
  input wire logic [7:0] prog_byte1,
  input wire logic [1:0] addr_mode,
  input wire logic [11:0] instr_pc,
  input wire logic [7:0] mem_addr,
  input wire logic mem_rd,
  input wire logic zero_flag,
  input wire logic carry_flag,
  input wire logic [11:0] pc_out,
  input wire logic pc_load,
  input wire logic busy,
  input wire logic done
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  wire take = start && !busy;
  wire is_alu = op >= `MABE_OP_ADD && op <= `MABE_OP_SLA;
  wire is_mem = op >= `MABE_OP_ADD && op <= `MABE_OP_DEC && op != `MABE_OP_CLR && src == `MABE_SRC_MEM;
  wire cond = (opcode[7] ? carry_flag : zero_flag) == opcode[6];
  wire [11:0] jr_tgt = opcode[4] ? instr_pc - {8'h00, opcode[3:0]} : instr_pc + {8'h00, opcode[3:0]} + 12'h001;
  sequence s_jr; take && op == `MABE_OP_JR; endsequence
  sequence s_load; pc_load && pc_out == jr_tgt; endsequence
  property p_start_busy; take |=> busy; endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy not raised");
  property p_alu_done; take && is_alu |-> ##[4:5] done; endproperty
  a_alu_done: assert property (p_alu_done) else $error("alu op late");
  property p_jrb_done; take && op == `MABE_OP_JRB |-> ##[5:6] done; endproperty
  a_jrb_done: assert property (p_jrb_done) else $error("bit branch late");
  property p_done_pulse; done |=> !done; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_jr_flags; s_jr |=> ($stable(zero_flag) && $stable(carry_flag))[*4]; endproperty
  a_jr_flags: assert property (p_jr_flags) else $error("branch moved flags");
  property p_and_carry; take && op == `MABE_OP_AND |=> $stable(carry_flag)[*5]; endproperty
  a_and_carry: assert property (p_and_carry) else $error("and moved carry");
  property p_jr_taken; s_jr ##0 cond |-> ##[1:5] s_load; endproperty
  a_jr_taken: assert property (p_jr_taken) else $error("branch target wrong");
  property p_jr_skip; s_jr ##0 !cond |=> !pc_load[*5]; endproperty
  a_jr_skip: assert property (p_jr_skip) else $error("branch taken wrongly");
  property p_dir_rd; take && is_mem && addr_mode == 2'h0 |-> ##[1:2] (mem_rd && mem_addr == prog_byte1); endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("direct read wrong");
  property p_short_rd; take && is_mem && addr_mode == 2'h1 |-> ##[1:2] (mem_rd && mem_addr == {6'h20, opcode[3:2]}); endproperty
  a_short_rd: assert property (p_short_rd) else $error("short read wrong");
  property p_jp; take && op == `MABE_OP_JP |-> ##[1:5] (pc_load && pc_out == {opcode[3:0], prog_byte1}); endproperty
  a_jp: assert property (p_jp) else $error("jump target wrong");
  sequence s_jrb; take && op == `MABE_OP_JRB; endsequence
  property p_jr_done; s_jr |-> !done[*3] ##1 done; endproperty
  a_jr_done: assert property (p_jr_done) else $error("short branch count wrong");
  property p_jrb_exact; s_jrb |-> !done[*6] ##1 done; endproperty
  a_jrb_exact: assert property (p_jrb_exact) else $error("bit branch count wrong");
endmodule // mabe_exec_sva
bind mabe_exec mabe_exec_sva sva_u (.clock(clock), .rstn(rstn), .start(start), .op(op), .src(src),
  .opcode(opcode), .prog_byte1(prog_byte1), .addr_mode(addr_mode), .instr_pc(instr_pc), .mem_addr(mem_addr),
  .mem_rd(mem_rd), .zero_flag(zero_flag), .carry_flag(carry_flag), .pc_out(pc_out), .pc_load(pc_load),
  .busy(busy), .done(done));
`default_nettype wire

// *** sim/mabe_exec_tb.sv ***
// Self-checking testbench of the execution datapath
`timescale 1ns/1ps
`default_nettype none
`include "mabe_regs.vh"
module mabe_exec_tb;
  logic clock = 0, rstn = 0, start = 0, ld;
  logic [3:0] op = 0;
  logic [1:0] src = 0, addr_mode = 0;
  logic [7:0] opcode = 0, prog_byte1 = 0, prog_byte2 = 0;
  logic [11:0] instr_pc = 12'h100, lpc;
  wire [7:0] mem_addr, mem_wdata, mem_rdata, acc_out;
  wire mem_rd, mem_wr, zero_flag, carry_flag, pc_load, busy, done;
  wire [11:0] pc_out;
  int err_total = 0, comparisons = 0, cyc, ticks = 0;
  mabe_exec dut_u (.clock(clock), .rstn(rstn), .start(start), .op(op), .src(src), .opcode(opcode),
    .prog_byte1(prog_byte1), .prog_byte2(prog_byte2), .addr_mode(addr_mode), .instr_pc(instr_pc),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .acc_out(acc_out), .zero_flag(zero_flag), .carry_flag(carry_flag), .pc_out(pc_out), .pc_load(pc_load),
    .busy(busy), .done(done));
  mabe_mem_model mem_u (.clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  initial begin
    forever #25 clock = ~clock;
  end
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (e !== g) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One instruction, entered and left at a falling edge
  task automatic run(input logic [3:0] o, input logic [1:0] s, m, input logic [7:0] oc, b1, b2);
    op = o; src = s; addr_mode = m; opcode = oc; prog_byte1 = b1; prog_byte2 = b2;
    start = 1'b1; ld = 0; cyc = 0;
    @(negedge clock) start = 1'b0;
    while (done !== 1'b1 && cyc < 20) begin
      if (pc_load === 1'b1) begin ld = 1; lpc = pc_out; end
      cyc++;
      @(negedge clock);
    end
    if (pc_load === 1'b1) begin ld = 1; lpc = pc_out; end
    chk("done", 1, done);
    @(negedge clock);
  endtask
  task automatic fl(input logic [7:0] a, input logic z, c);
    chk("acc", a, acc_out);
    chk("zero", z, zero_flag);
    chk("carry", c, carry_flag);
  endtask
  task automatic t_alu;
    run(`MABE_OP_ADD, `MABE_SRC_IMM, 0, 0, 8'h80, 0); fl(8'h80, 0, 0);
    chk("alucyc", `MABE_CYC_ALU, cyc);
    run(`MABE_OP_ADD, `MABE_SRC_IMM, 0, 0, 8'h80, 0); fl(8'h00, 1, 1);
    mem_u.mem[8'h10] = 8'h05;
    run(`MABE_OP_SUB, `MABE_SRC_MEM, 0, 0, 8'h10, 0); chk("sub", 8'hFB, acc_out);
    chk("subcyc", `MABE_CYC_ALU, cyc);
    run(`MABE_OP_CMP, `MABE_SRC_IMM, 0, 0, 8'hFB, 0); chk("cmp", 8'hFB, acc_out); chk("cz", 1, zero_flag);
    run(`MABE_OP_AND, `MABE_SRC_IMM, 0, 0, 8'h0F, 0); chk("and", 8'h0B, acc_out);
    run(`MABE_OP_COM, `MABE_SRC_ACC, 0, 0, 0, 0); chk("com", 8'hF4, acc_out);
    run(`MABE_OP_ADD, `MABE_SRC_IMM, 0, 0, 8'h8C, 0); fl(8'h80, 0, 1);
    run(`MABE_OP_RLC, `MABE_SRC_ACC, 0, 0, 0, 0); fl(8'h01, 0, 1);
    run(`MABE_OP_SLA, `MABE_SRC_ACC, 0, 0, 0, 0); fl(8'h02, 0, 0);
    run(`MABE_OP_DEC, `MABE_SRC_ACC, 0, 0, 0, 0);
    run(`MABE_OP_DEC, `MABE_SRC_ACC, 0, 0, 0, 0); fl(8'h00, 1, 0);
    run(`MABE_OP_INC, `MABE_SRC_ACC, 0, 0, 0, 0); fl(8'h01, 0, 0);
    $display("alu test done");
  endtask
  task automatic t_mem;
    logic [7:0] al [3] = '{8'h00, 8'h7F, 8'hFF};
    foreach (al[i]) begin
      mem_u.mem[al[i]] = 8'h01;
      run(`MABE_OP_INC, `MABE_SRC_MEM, 0, 0, al[i], 0); chk("inc", 8'h02, mem_u.mem[al[i]]);
      run(`MABE_OP_DEC, `MABE_SRC_MEM, 0, 0, al[i], 0);
      run(`MABE_OP_DEC, `MABE_SRC_MEM, 0, 0, al[i], 0); chk("dec", 0, mem_u.mem[al[i]]);
      chk("dz", 1, zero_flag);
      mem_u.mem[al[i]] = 8'h5A;
      run(`MABE_OP_CLR, `MABE_SRC_MEM, 0, 0, al[i], 0); chk("clr", 0, mem_u.mem[al[i]]);
    end
    mem_u.mem[8'h83] = 8'h11;
    run(`MABE_OP_INC, `MABE_SRC_MEM, 1, 8'h0C, 0, 0); chk("sd", 8'h12, mem_u.mem[8'h83]);
    mem_u.mem[8'h80] = 8'h30;
    mem_u.mem[8'h81] = 8'h31;
    mem_u.mem[8'h30] = 8'h5A;
    mem_u.mem[8'h31] = 8'hA5;
    run(`MABE_OP_CLR, `MABE_SRC_MEM, 2, 0, 0, 0); chk("clrx", 0, mem_u.mem[8'h30]);
    run(`MABE_OP_CLR, `MABE_SRC_MEM, 3, 0, 0, 0); chk("clry", 0, mem_u.mem[8'h31]);
    chk("ptrx", 8'h30, mem_u.mem[8'h80]);
    $display("memory test done");
  endtask
  task automatic t_jr;
    logic cnd;
    for (int f = 0; f < 2; f++) begin
      run(`MABE_OP_CLR, `MABE_SRC_ACC, 0, 0, 0, 0);
      if (f == 1) begin
        run(`MABE_OP_ADD, `MABE_SRC_IMM, 0, 0, 8'hFF, 0);
        run(`MABE_OP_ADD, `MABE_SRC_IMM, 0, 0, 8'h02, 0);
      end
      for (int k = 0; k < 4; k++) begin
        cnd = (k[1] ? f[0] : !f[0]) == k[0];
        run(`MABE_OP_JR, 0, 0, {k[1:0], 1'b0, k[0], 4'hF}, 0, 0); chk("jr", cnd, ld);
        if (cnd) chk("jrpc", k[0] ? 12'h0F1 : 12'h110, lpc);
        chk("jrcyc", `MABE_CYC_JR, cyc);
        chk("jrz", !f[0], zero_flag);
      end
    end
    $display("short branch test done");
  endtask
  task automatic t_jrb;
    mem_u.mem[8'h40] = 8'hA5;
    for (int b = 0; b < 16; b++) begin
      run(`MABE_OP_JRB, `MABE_SRC_MEM, 0, {b[2:0], b[3], 4'h0}, 8'h40, b[0] ? 8'h80 : 8'h7F);
      chk("jrb", 8'hA5 >> b[2:0] & 1 ^ !b[3], ld);
      if (ld) chk("jrbpc", b[0] ? 12'h082 : 12'h181, lpc);
      chk("jrbc", 8'hA5 >> b[2:0] & 1, carry_flag);
      chk("jrbcyc", `MABE_CYC_JRB, cyc);
    end
    run(`MABE_OP_JP, 0, 0, 8'h0A, 8'h34, 0); chk("jp", 12'hA34, lpc);
    chk("jpcyc", `MABE_CYC_JP, cyc);
    $display("bit branch test done");
  endtask
  always @(posedge clock) begin
    ticks++;
    if (ticks == 3000) begin
      err_total++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (5) @(negedge clock);
    rstn = 1'b1;
    t_alu;
    t_mem;
    t_jr;
    t_jrb;
    tally_and_finish;
  end
endmodule // mabe_exec_tb
`default_nettype wire
